// >>> hw/mwd_regs.svh
// register indices, field layout, reset values and timing counts of the watchdog
// Overview of operation
// - frequency field holds oscillator MHz rounded up, resets to 25
// - frequency writes outside 5..100 are ignored and answered with an error
// - tick rate, reset delay and sleep clock all derive from the frequency
// - countdown runs in 1 ms ticks, timeouts from 1 ms to about 65 s
// - countdown advances only in the full power state, holds otherwise
// - mismatching complement gets an error answer, a match gets okay
// - software kicks periodically; a kick in the run state restarts from the timeout
// - expiry resets the processor tile
// - bits 31:16 read the current count and ignore writes
// - bits 15:0 hold the timeout in ms, reset value 1000
// - writing zero to the disable register enables the watchdog
// - writing the key resets and disables; key is also the reset value
`ifndef MWD_REGS_SVH
`define MWD_REGS_SVH
`define MWD_IDX_FREQ    10'h051
`define MWD_IDX_WDOG    10'h0d6
`define MWD_IDX_DIS     10'h0d7
`define MWD_IDX_ISTAT   10'h0e0
`define MWD_IDX_IMASK   10'h0e1
`define MWD_FREQ_RST    7'h19
`define MWD_FREQ_MIN    32'h00000005
`define MWD_FREQ_MAX    32'h00000064
`define MWD_TMO_RST     16'h03e8
`define MWD_DIS_KEY     32'h0d15ab1e
`define MWD_EN_KEY      32'h00000000
`define MWD_TICK_MS     1
`define MWD_TICK_US     (`MWD_TICK_MS * 1000)
`define MWD_RST_HOLD_MS 1
`endif

// >>> hw/mwd_pkg.sv
// types shared by the watchdog design files
package mwd_pkg;
    typedef enum logic [1:0] {
        WD_OFF  = 2'h0,
        WD_RUN  = 2'h1,
        WD_HOLD = 2'h2
    } mwd_state_e;
    typedef enum logic [2:0] {
        REG_NONE  = 3'h0,
        REG_FREQ  = 3'h1,
        REG_WDOG  = 3'h2,
        REG_DIS   = 3'h3,
        REG_ISTAT = 3'h4,
        REG_IMASK = 3'h5
    } mwd_reg_e;
    typedef struct packed {
        logic nack;
        logic expire;
    } mwd_evt_s;
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] timeout;
    } mwd_wdog_s;
endpackage : mwd_pkg

// >>> hw/mwd_tick_gen.sv
// millisecond tick prescaler on the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module mwd_tick_gen
#(
    parameter int unsigned TICK_US = 1000,
    parameter int unsigned W       = 17
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         run,
    input  wire logic         clear,
    input  wire logic [6:0]   mhz,
    output logic              tick
);
    logic [W-1:0] pre_r;
    logic [W-1:0] limit;
    logic [W-1:0] gap_r;
    logic [6:0]   mhzSeen_r;

    // cycles per tick follow the programmed frequency
    assign limit = W'(mhz * TICK_US);

    always_ff @(posedge clk_sys)
    begin
        if (rst || clear)
        begin
            pre_r <= '0;
            tick  <= 1'b0;
        end
        else if (run && pre_r >= W'(limit - W'(1)))
        begin
            pre_r <= '0;
            tick  <= 1'b1;
        end
        else
        begin
            if (run)
                pre_r <= pre_r + W'(1);
            tick <= 1'b0;
        end
    end

    // helper: running cycles since the last tick, frequency held constant;
    // after a clear or a new frequency it stays zero until the next tick,
    // because a clear restarts the prescaler and a new frequency leaves it at its old position, so that period differs
    always_ff @(posedge clk_sys)
    begin
        mhzSeen_r <= mhz;
        if (rst || clear || mhz != mhzSeen_r)
            gap_r <= '0;
        else if (tick)
            gap_r <= run ? W'(1) : '0;
        else if (run && gap_r != '0)
            gap_r <= gap_r + W'(1);
    end

    tick_period_a: assert property (@(posedge clk_sys) disable iff (rst)
        tick && gap_r != '0 |-> gap_r == limit)
        else $error("tick period differs from mhz times cycles per mhz");
endmodule : mwd_tick_gen
`default_nettype wire

// >>> hw/mwd_watchdog.sv
// watchdog top: apb registers, ms countdown, tile reset and interrupt
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mwd_regs.svh"
module mwd_watchdog
    import mwd_pkg::*;
#(
    parameter int unsigned TICK_US     = `MWD_TICK_US,
    parameter int unsigned RST_HOLD_MS = `MWD_RST_HOLD_MS
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fullPowerState,
    output logic             tileReset,
    output logic             rtcTick,
    output logic             irq
);
    // word index is the byte address divided by four
    function automatic mwd_reg_e mwd_decode(input logic [11:0] addr);
        mwd_reg_e r;
        r = REG_NONE;
        if (addr[1:0] != 2'h0)
            r = REG_NONE;
        else if (addr[11:2] == `MWD_IDX_FREQ)
            r = REG_FREQ;
        else if (addr[11:2] == `MWD_IDX_WDOG)
            r = REG_WDOG;
        else if (addr[11:2] == `MWD_IDX_DIS)
            r = REG_DIS;
        else if (addr[11:2] == `MWD_IDX_ISTAT)
            r = REG_ISTAT;
        else if (addr[11:2] == `MWD_IDX_IMASK)
            r = REG_IMASK;
        return r;
    endfunction : mwd_decode

    function automatic logic mwd_freq_ok(input logic [31:0] v);
        return v >= `MWD_FREQ_MIN && v <= `MWD_FREQ_MAX;
    endfunction : mwd_freq_ok

    mwd_state_e  state_r;
    logic [6:0]  freq_r;
    mwd_wdog_s   wdog_r;
    logic [31:0] dis_r;
    logic [7:0]  hold_r;
    mwd_evt_s    stat_r;
    mwd_evt_s    mask_r;
    mwd_evt_s    evt;
    mwd_evt_s    w1c;
    logic [31:0] prdata_r;
    logic        awakeMeta_r;
    logic        full_power_state_r;
    mwd_reg_e    rsel;
    logic        acc;
    logic        wrAcc;
    logic        freqBad;
    logic        cmplBad;
    logic        freqWr;
    logic        kick;
    logic        disWr;
    logic        enCmd;
    logic        offCmd;
    logic        tick;
    logic        tickRun;
    logic        tickClr;
    logic        expire;

    // power state pin comes from another domain
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            awakeMeta_r <= 1'b0;
            full_power_state_r     <= 1'b0;
        end
        else
        begin
            awakeMeta_r <= fullPowerState;
            full_power_state_r     <= awakeMeta_r;
        end
    end

    assign rsel    = mwd_decode(paddr);
    assign acc     = psel && penable;
    assign wrAcc   = acc && pwrite;
    assign freqBad = rsel == REG_FREQ && !mwd_freq_ok(pwdata);
    assign cmplBad = rsel == REG_WDOG && pwdata[31:16] != ~pwdata[15:0];
    assign freqWr  = wrAcc && rsel == REG_FREQ && !freqBad;
    assign kick    = wrAcc && rsel == REG_WDOG && !cmplBad;
    assign disWr   = wrAcc && rsel == REG_DIS;
    assign enCmd   = disWr && pwdata == `MWD_EN_KEY;
    assign offCmd  = disWr && pwdata == `MWD_DIS_KEY;

    // zero wait states; error answer doubles as the negative acknowledge
    assign pready  = 1'b1;
    assign pslverr = acc && (rsel == REG_NONE || (pwrite && (freqBad || cmplBad)));
    assign prdata  = prdata_r;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            freq_r <= `MWD_FREQ_RST;
        else if (freqWr)
            freq_r <= pwdata[6:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            wdog_r.timeout <= `MWD_TMO_RST;
        else if (kick)
            wdog_r.timeout <= pwdata[15:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            dis_r <= `MWD_DIS_KEY;
        else if (disWr)
            dis_r <= pwdata;
    end

    // the countdown prescaler only runs while counting or holding reset
    assign tickRun = (state_r == WD_RUN && full_power_state_r) || state_r == WD_HOLD;
    assign tickClr = kick || enCmd || offCmd;
    assign expire  = state_r == WD_RUN && tick && wdog_r.count <= 16'h0001
                     && !kick && !offCmd;

    mwd_tick_gen #(
        .TICK_US (TICK_US)
    ) u_wd_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (tickRun),
        .clear   (tickClr),
        .mhz     (freq_r),
        .tick    (tick)
    );

    // sleep clock reference: free running ms tick from the same setting
    mwd_tick_gen #(
        .TICK_US (TICK_US)
    ) u_rtc_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (1'b1),
        .clear   (1'b0),
        .mhz     (freq_r),
        .tick    (rtcTick)
    );

    // disable key beats any other activity, including a pending reset
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_r      <= WD_OFF;
            wdog_r.count <= 16'h0000;
            hold_r       <= 8'h00;
        end
        else if (offCmd)
        begin
            state_r      <= WD_OFF;
            wdog_r.count <= 16'h0000;
            hold_r       <= 8'h00;
        end
        else
        begin
            case (state_r)
                WD_OFF:
                begin
                    if (enCmd)
                    begin
                        state_r      <= WD_RUN;
                        wdog_r.count <= kick ? pwdata[15:0] : wdog_r.timeout;
                    end
                end
                WD_RUN:
                begin
                    if (kick)
                        wdog_r.count <= pwdata[15:0];
                    else if (expire)
                    begin
                        state_r      <= WD_HOLD;
                        wdog_r.count <= wdog_r.timeout;
                        hold_r       <= 8'(RST_HOLD_MS);
                    end
                    else if (tick)
                        wdog_r.count <= wdog_r.count - 16'h0001;
                end
                WD_HOLD:
                begin
                    // reset length scales with the programmed frequency
                    if (tick)
                    begin
                        if (hold_r <= 8'h01)
                            state_r <= WD_RUN;
                        hold_r <= hold_r - 8'h01;
                    end
                end
                default:
                    state_r <= WD_OFF;
            endcase
        end
    end

    assign tileReset = state_r == WD_HOLD;

    assign evt.expire = expire;
    assign evt.nack   = wrAcc && (freqBad || cmplBad);
    assign w1c        = (wrAcc && rsel == REG_ISTAT) ? mwd_evt_s'(pwdata[1:0]) : '0;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            stat_r <= '0;
        else
            stat_r <= (stat_r & ~w1c) | evt;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            mask_r <= '0;
        else if (wrAcc && rsel == REG_IMASK)
            mask_r <= mwd_evt_s'(pwdata[1:0]);
    end

    assign irq = |(stat_r & mask_r);

    // read data latched in the setup cycle so it is stable in access
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            prdata_r <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            case (rsel)
                REG_FREQ:  prdata_r <= {25'h0000000, freq_r};
                REG_WDOG:  prdata_r <= wdog_r;
                REG_DIS:   prdata_r <= dis_r;
                REG_ISTAT: prdata_r <= {30'h00000000, stat_r};
                REG_IMASK: prdata_r <= {30'h00000000, mask_r};
                default:   prdata_r <= 32'h00000000;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    reset_values_a: assert property ($fell(rst) |->
        freq_r == `MWD_FREQ_RST && wdog_r.timeout == `MWD_TMO_RST
        && dis_r == `MWD_DIS_KEY && state_r == WD_OFF)
        else $error("reset values wrong");

    freq_range_a: assert property (wrAcc && rsel == REG_FREQ
        && !mwd_freq_ok(pwdata) |-> pslverr ##1 $stable(freq_r))
        else $error("bad frequency accepted");

    freq_store_a: assert property (wrAcc && rsel == REG_FREQ
        && mwd_freq_ok(pwdata) |-> !pslverr ##1 freq_r == $past(pwdata[6:0]))
        else $error("good frequency not stored");

    cmpl_answer_a: assert property (wrAcc && rsel == REG_WDOG |->
        pslverr == (pwdata[31:16] != ~pwdata[15:0]))
        else $error("complement answer wrong");

    kick_reload_a: assert property (kick && state_r == WD_RUN && !offCmd
        |=> wdog_r.count == $past(pwdata[15:0]) && wdog_r.timeout == wdog_r.count)
        else $error("kick did not reload count");

    count_hold_a: assert property (state_r == WD_RUN && !full_power_state_r
        && !kick && !offCmd |=> $stable(wdog_r.count))
        else $error("count moved outside full power state");

    count_step_a: assert property (state_r == WD_RUN && tick && !kick
        && !offCmd && wdog_r.count > 16'h0001
        |=> wdog_r.count == $past(wdog_r.count) - 16'h0001)
        else $error("count did not step by one tick");

    expire_reset_a: assert property (expire |=> tileReset
        && wdog_r.count == wdog_r.timeout)
        else $error("expiry did not reset tile");

    readback_a: assert property (psel && !penable && !pwrite
        && rsel == REG_WDOG ##1 psel && penable
        |-> prdata == {$past(wdog_r.count), $past(wdog_r.timeout)})
        else $error("count readback wrong");

    count_ro_a: assert property (wrAcc && rsel == REG_WDOG && state_r == WD_OFF
        |=> wdog_r.count == 16'h0000)
        else $error("count took a write");

    disable_key_a: assert property (offCmd |=>
        state_r == WD_OFF && wdog_r.count == 16'h0000 && !tileReset)
        else $error("key did not disable");

    enable_zero_a: assert property (enCmd && state_r == WD_OFF |=>
        state_r == WD_RUN)
        else $error("zero did not enable");

    other_value_a: assert property (disWr && !enCmd && !offCmd
        && state_r == WD_OFF |=> state_r == WD_OFF)
        else $error("other value changed enable state");

    irq_level_a: assert property (stat_r.expire && mask_r.expire |-> irq)
        else $error("masked-in status did not raise irq");

    expire_cov: cover property (state_r == WD_RUN ##1 tileReset [*2] ##1 !tileReset);
    nack_cov: cover property (evt.nack ##1 irq);
    kick_cov: cover property (kick && state_r == WD_RUN && wdog_r.count != 16'h0000);
    sleep_cov: cover property (state_r == WD_RUN && !full_power_state_r && tick);
endmodule : mwd_watchdog
`default_nettype wire

// >>> sim/mwd_watchdog_tb.sv
// self-checking bench for the millisecond watchdog
`timescale 1ns/1ps
`default_nettype none
`include "mwd_regs.svh"
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin badCount++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module mwd_watchdog_tb
    import mwd_pkg::*;
;
    typedef struct packed {
        logic        w;
        logic [9:0]  idx;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] e;
        logic        err;
    } mwd_row_s;
    localparam logic [9:0] FR = `MWD_IDX_FREQ;
    localparam logic [9:0] WD = `MWD_IDX_WDOG;
    localparam logic [9:0] DI = `MWD_IDX_DIS;
    localparam logic [9:0] IS = `MWD_IDX_ISTAT;
    localparam logic [9:0] IM = `MWD_IDX_IMASK;
    logic        clk_sys;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fullPowerState;
    logic        tileReset;
    logic        rtcTick;
    logic        irq;
    logic        sawRst;
    logic [31:0] rd;
    logic [15:0] c1;
    logic        er;
    int          badCount;
    int          checksDone;
    int          n;
    // ordinary register traffic: write/read, index, data, read mask, expected, error
    mwd_row_s rows [20] = '{
        '{1'b0, FR, 32'h0, 32'hffffffff, 32'h19, 1'b0},
        '{1'b0, WD, 32'h0, 32'hffffffff, 32'h3e8, 1'b0},
        '{1'b0, DI, 32'h0, 32'hffffffff, 32'h0d15ab1e, 1'b0},
        '{1'b1, FR, 32'h4, 32'h0, 32'h0, 1'b1},
        '{1'b1, FR, 32'h65, 32'h0, 32'h0, 1'b1},
        '{1'b1, FR, 32'h00010005, 32'h0, 32'h0, 1'b1},
        '{1'b0, FR, 32'h0, 32'hffffffff, 32'h19, 1'b0},
        '{1'b0, IS, 32'h0, 32'h2, 32'h2, 1'b0},
        '{1'b1, IS, 32'h3, 32'h0, 32'h0, 1'b0},
        '{1'b0, IS, 32'h0, 32'h3, 32'h0, 1'b0},
        '{1'b1, FR, 32'h64, 32'h0, 32'h0, 1'b0},
        '{1'b0, FR, 32'h0, 32'hffffffff, 32'h64, 1'b0},
        '{1'b1, FR, 32'h5, 32'h0, 32'h0, 1'b0},
        '{1'b0, FR, 32'h0, 32'hffffffff, 32'h5, 1'b0},
        '{1'b1, WD, 32'h12340003, 32'h0, 32'h0, 1'b1},
        '{1'b0, WD, 32'h0, 32'hffff, 32'h3e8, 1'b0},
        '{1'b1, WD, 32'hfffc0003, 32'h0, 32'h0, 1'b0},
        '{1'b0, WD, 32'h0, 32'hffff, 32'h3, 1'b0},
        '{1'b0, 10'h000, 32'h0, 32'hffffffff, 32'h0, 1'b1},
        '{1'b1, 10'h3ff, 32'h1, 32'h0, 32'h0, 1'b1}
    };

    mwd_watchdog #(.TICK_US(1), .RST_HOLD_MS(1)) i_dut (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .fullPowerState(fullPowerState),
        .tileReset     (tileReset),
        .rtcTick       (rtcTick),
        .irq           (irq)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
        if (tileReset === 1'b1) sawRst <= 1'b1;

    // idle edge first, so a release is never followed by a setup in one time step
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic waitFor(ref logic s, output int k);
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end while (s !== 1'b1 && k < 200);
    endtask : waitFor

    task automatic endOfTest();
        $display("checks %0d, mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : endOfTest

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        badCount++;
        $display("mismatch t=%0t watchdog ran out", $time);
        endOfTest();
    end

    initial
    begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {fullPowerState, sawRst, badCount, checksDone} = {1'b1, 1'b0, 64'h0};
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].idx, rows[i].d);
            `CHK(er, rows[i].err)
            if (!rows[i].w) `CHK(rd & rows[i].m, rows[i].e)
        end
        $display("register table done");
        // freq 5, timeout 3: expiry near 15 cycles after enable
        apb(1'b1, IM, 32'h1);
        apb(1'b1, DI, 32'h0);
        apb(1'b0, WD, 32'h0);
        `CHK(rd[31:16], 16'h0003)
        waitFor(tileReset, n);
        `CHK(n inside {[7:16]}, 1'b1)
        `CHK(irq, 1'b1)
        apb(1'b1, IM, 32'h0);
        // mask lands at the access edge; look once it has settled
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        apb(1'b1, IS, 32'h1);
        apb(1'b1, IM, 32'h1);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        $display("expiry done");
        // kicks every 3 cycles stay ahead of a 5-cycle tick
        while (tileReset !== 1'b0) @(posedge clk_sys);
        sawRst = 1'b0;
        repeat (8) apb(1'b1, WD, 32'hfffc0003);
        `CHK(sawRst, 1'b0)
        $display("kick done");
        fullPowerState <= 1'b0;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, WD, 32'h0);
        c1 = rd[31:16];
        sawRst = 1'b0;
        repeat (40) @(posedge clk_sys);
        apb(1'b0, WD, 32'h0);
        `CHK(rd[31:16], c1)
        `CHK(sawRst, 1'b0)
        fullPowerState <= 1'b1;
        $display("power hold done");
        waitFor(tileReset, n);
        apb(1'b1, DI, `MWD_DIS_KEY);
        repeat (2) @(posedge clk_sys);
        `CHK(tileReset, 1'b0)
        apb(1'b1, DI, 32'h12345678);
        sawRst = 1'b0;
        repeat (40) @(posedge clk_sys);
        apb(1'b0, WD, 32'h0);
        `CHK(rd[31:16], 16'h0000)
        `CHK(sawRst, 1'b0)
        $display("disable done");
        for (int f = 5; f <= 7; f += 2)
        begin
            apb(1'b1, FR, f);
            waitFor(rtcTick, n);
            waitFor(rtcTick, n);
            `CHK(n, f)
        end
        $display("tick rate done");
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, FR, 32'h0);
        `CHK(rd, 32'h00000019)
        apb(1'b0, DI, 32'h0);
        `CHK(rd, 32'h0d15ab1e)
        `CHK(irq, 1'b0)
        $display("second reset done");
        endOfTest();
    end
endmodule : mwd_watchdog_tb
`default_nettype wire
